// ---- hw/pic_top.sv ----
`timescale 1ns/10ps
`default_nettype none
//////////////////////////////////////////////////////////////////////////////
module pic_top (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire pic_pkg::pic_bus_s bus,
    output logic [15:0] rd_data_q,
    input wire logic nmi_pin,
    input wire logic [pic_pkg::NUM_IRQ-1:0] ext_req_pins_n,
    input wire logic [3:0] enc_level_pins_n,
    input wire logic [pic_pkg::NUM_PORT-1:0] port_irq_in,
    input wire logic [pic_pkg::NUM_PERIPH-1:0] periph_req,
    input wire logic refresh_req,
    input wire logic cpu_block_bit,
    input wire logic [3:0] cpu_mask_level,
    input wire logic cpu_ack,
    input wire logic sleep_mode,
    input wire logic standby_mode,
    input wire logic rtc_osc_used,
    output pic_pkg::pic_req_s cpu_req_q,
    output logic wakeup_q,
    output logic irq_notify_n_q
);
    import pic_pkg::*;

    //////////////////////////////////////////////////////////////////////////
    // Pin synchronisers: stage 1 is read only by stage 2
    logic [26:0] sync1_q;
    logic [26:0] sync2_q;
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            sync1_q <= 27'h7ffffff;
            sync2_q <= 27'h7ffffff;
        end else begin
            sync1_q <= {nmi_pin, ext_req_pins_n, enc_level_pins_n, port_irq_in};
            sync2_q <= sync1_q;
        end
    end

    logic nmi_s;
    logic [NUM_IRQ-1:0] irq_n_s;
    logic [3:0] enc_s;
    logic [NUM_PORT-1:0] port_s;
    assign nmi_s = sync2_q[26];
    assign irq_n_s = sync2_q[25:20];
    assign enc_s = sync2_q[19:16];
    assign port_s = sync2_q[15:0];

    //////////////////////////////////////////////////////////////////////////
    // Control registers
    logic edge_sel_q;
    logic [15:0] pinsense_q;
    logic [15:0] portsense_q;
    logic [15:0] porten_q;
    logic [15:0] prio_a_q;
    logic [15:0] prio_b_q;
    logic [15:0] prio_c_q;
    logic [15:0] prio_d_q;
    logic [15:0] prio_e_q;

    logic nmi_dis;
    logic blk_ovr;
    logic [NUM_IRQ-1:0] irq_edge_mode;
    assign nmi_dis = pinsense_q[PINSENSE_DIS_BIT];
    assign blk_ovr = pinsense_q[PINSENSE_OVR_BIT];
    assign irq_edge_mode = pinsense_q[NUM_IRQ-1:0];

    function automatic logic wr_at(input pic_bus_s b, input logic [31:0] ofs);
        wr_at = b.wr && (b.addr == ofs);
    endfunction : wr_at

    // Plain read/write registers, all cleared by reset
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            pinsense_q <= REG_RST;
            portsense_q <= REG_RST;
            porten_q <= REG_RST;
            prio_a_q <= REG_RST;
            prio_b_q <= REG_RST;
            prio_c_q <= REG_RST;
            prio_d_q <= REG_RST;
            prio_e_q <= REG_RST;
        end else begin
            if (wr_at(bus, OFS_PINSENSE)) pinsense_q <= bus.wdata;
            if (wr_at(bus, OFS_PORTSENSE)) portsense_q <= bus.wdata;
            if (wr_at(bus, OFS_PORTEN)) porten_q <= bus.wdata;
            if (wr_at(bus, OFS_PRIO_A)) prio_a_q <= bus.wdata;
            if (wr_at(bus, OFS_PRIO_B)) prio_b_q <= bus.wdata;
            if (wr_at(bus, OFS_PRIO_C)) prio_c_q <= bus.wdata;
            if (wr_at(bus, OFS_PRIO_D)) prio_d_q <= bus.wdata;
            if (wr_at(bus, OFS_PRIO_E)) prio_e_q <= bus.wdata;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Nonmaskable edge select and blanking after a change
    logic [4:0] blank_cnt_q;
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            edge_sel_q <= 1'b0;
            blank_cnt_q <= 5'h00;
        end else begin
            if (wr_at(bus, OFS_NMICTL)) edge_sel_q <= bus.wdata[NMICTL_EDGE_BIT];
            // Flipping polarity looks like an edge; hide it. A rewrite of the same
            // polarity must not stall the count, or blanking would stretch past 20 cycles
            if (wr_at(bus, OFS_NMICTL) && (bus.wdata[NMICTL_EDGE_BIT] != edge_sel_q)) begin
                blank_cnt_q <= NMI_BLANK_CYC;
            end else if (blank_cnt_q != 5'h00) begin
                blank_cnt_q <= blank_cnt_q - 5'h01;
            end
        end
    end

    // Edge detector on the synchronised pin
    logic nmi_prev_q;
    logic nmi_pend_q;
    logic nmi_edge;
    logic nmi_ok;
    assign nmi_edge = (blank_cnt_q == 5'h00) && (edge_sel_q ? (nmi_s && !nmi_prev_q)
                                                            : (!nmi_s && nmi_prev_q));
    assign nmi_ok = !nmi_dis && (blk_ovr || !cpu_block_bit || sleep_mode || standby_mode);

    // Pending flag: a new edge wins over the CPU's acceptance
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            nmi_prev_q <= 1'b1;
            nmi_pend_q <= 1'b0;
        end else begin
            nmi_prev_q <= nmi_s;
            if (nmi_edge) nmi_pend_q <= 1'b1;
            else if (cpu_ack && cpu_req_q.nmi) nmi_pend_q <= 1'b0;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // External request pins: edge latch or live level
    logic [NUM_IRQ-1:0] irq_prev_n_q;
    logic [NUM_IRQ-1:0] irq_latch_q;
    logic [NUM_IRQ-1:0] irq_fall;
    logic [NUM_IRQ-1:0] irq_act;
    assign irq_fall = irq_prev_n_q & ~irq_n_s;
    assign irq_act = (irq_edge_mode & irq_latch_q) | (~irq_edge_mode & ~irq_n_s);

    // Software clears with a 0; a concurrent edge still sets
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            irq_prev_n_q <= {NUM_IRQ{1'b1}};
            irq_latch_q <= REQ_RST[NUM_IRQ-1:0];
        end else begin
            irq_prev_n_q <= irq_n_s;
            if (wr_at(bus, OFS_REQ0))
                irq_latch_q <= (irq_latch_q & bus.wdata[NUM_IRQ-1:0]) | (irq_fall & irq_edge_mode);
            else
                irq_latch_q <= irq_latch_q | (irq_fall & irq_edge_mode);
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Encoded level pins: two equal samples before a level is taken
    logic [3:0] enc_prev_q;
    logic [3:0] enc_stable_q;
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            enc_prev_q <= 4'hf;
            enc_stable_q <= 4'hf;
        end else begin
            enc_prev_q <= enc_s;
            if (enc_prev_q == enc_s) enc_stable_q <= enc_s;
        end
    end

    // Port inputs: level sensed, polarity per bit, then enabled
    logic [NUM_PORT-1:0] port_act;
    assign port_act = porten_q & ~(port_s ^ portsense_q);

    //////////////////////////////////////////////////////////////////////////
    // Per-source levels, listed in ranking order
    logic [4:0] src_lvl [NUM_SRC];
    logic [47:0] per_prio;
    assign per_prio = {prio_e_q, prio_b_q, prio_a_q};

    always_comb begin
        src_lvl[SRC_NMI] = (nmi_pend_q && nmi_ok) ? LVL_NMI : 5'h00;
        for (int i = 0; i < NUM_IRQ; i++) begin
            logic [3:0] p;
            p = (i < 4) ? prio_c_q[4*i +: 4] : prio_d_q[4*(i-4) +: 4];
            src_lvl[int'(SRC_IRQ0) + i] = irq_act[i] ? {1'b0, p} : 5'h00;
        end
        src_lvl[SRC_ENC] = {1'b0, ~enc_stable_q};
        src_lvl[SRC_PLO] = (|port_act[7:0]) ? {1'b0, prio_d_q[PRIOD_PLO_POS +: 4]} : 5'h00;
        src_lvl[SRC_PHI] = (|port_act[15:8]) ? {1'b0, prio_d_q[PRIOD_PHI_POS +: 4]} : 5'h00;
        for (int i = 0; i < NUM_PERIPH; i++) begin
            src_lvl[int'(SRC_PER0) + i] = periph_req[i] ? {1'b0, per_prio[4*i +: 4]} : 5'h00;
        end
    end

    // Strictly greater keeps the earlier source on a tie
    logic [4:0] best_lvl;
    logic [4:0] best_src;
    always_comb begin
        best_lvl = 5'h00;
        best_src = 5'h00;
        for (int i = 0; i < NUM_SRC; i++) begin
            if (src_lvl[i] > best_lvl) begin
                best_lvl = src_lvl[i];
                best_src = 5'(i);
            end
        end
    end

    logic req_d;
    assign req_d = best_lvl > {1'b0, cpu_mask_level};

    // Standby wake sources
    logic wake_d;
    logic [4:0] plo_lvl;
    logic low_wake;
    assign plo_lvl = (|port_act[1:0]) ? {1'b0, prio_d_q[PRIOD_PLO_POS +: 4]} : 5'h00;
    always_comb begin
        low_wake = plo_lvl > {1'b0, cpu_mask_level};
        for (int i = 0; i < 5; i++) begin
            if (src_lvl[int'(SRC_IRQ0) + i] > {1'b0, cpu_mask_level}) low_wake = 1'b1;
        end
    end
    assign wake_d = standby_mode && ((nmi_pend_q && !nmi_dis) || (rtc_osc_used && low_wake));

    //////////////////////////////////////////////////////////////////////////
    // CPU request, wake and notification outputs
    // Only the valid and nmi flags, level and source go out: the mask level is never written back
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            cpu_req_q <= '0;
            wakeup_q <= 1'b0;
            irq_notify_n_q <= 1'b1;
        end else begin
            cpu_req_q.valid <= req_d;
            cpu_req_q.nmi <= req_d && (best_src == SRC_NMI);
            cpu_req_q.level <= req_d ? best_lvl : 5'h00;
            cpu_req_q.src <= req_d ? best_src : 5'h00;
            wakeup_q <= wake_d;
            irq_notify_n_q <= !(req_d || refresh_req);
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Read data, valid the cycle after the strobe; unmapped reads give zero
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            rd_data_q <= 16'h0000;
        end else if (bus.rd) begin
            case (bus.addr)
                OFS_NMICTL: rd_data_q <= {nmi_s, 6'h00, edge_sel_q, 8'h00};
                OFS_PINSENSE: rd_data_q <= pinsense_q;
                OFS_PORTSENSE: rd_data_q <= portsense_q;
                OFS_PORTEN: rd_data_q <= porten_q;
                OFS_PRIO_A: rd_data_q <= prio_a_q;
                OFS_PRIO_B: rd_data_q <= prio_b_q;
                OFS_PRIO_C: rd_data_q <= prio_c_q;
                OFS_PRIO_D: rd_data_q <= prio_d_q;
                OFS_PRIO_E: rd_data_q <= prio_e_q;
                OFS_REQ0: rd_data_q <= {10'h000, irq_act};
                OFS_REQ1: rd_data_q <= {8'h00, port_act[7:0]};
                OFS_REQ2: rd_data_q <= {8'h00, port_act[15:8]};
                default: rd_data_q <= 16'h0000;
            endcase
        end else begin
            rd_data_q <= 16'h0000;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    a_req_nonzero: assert property (cpu_req_q.valid |-> cpu_req_q.level != 5'h00)
        else $error("request with level zero");
    a_nmi_top_lvl: assert property (cpu_req_q.nmi |-> cpu_req_q.level == 5'h10)
        else $error("nonmaskable request not at level 16");
    a_nmi_gate_ok: assert property (cpu_req_q.nmi |-> !$past(pinsense_q[15]))
        else $error("nonmaskable request while disabled");
    a_nmi_blank_hold: assert property ($rose(nmi_pend_q) |-> $past(blank_cnt_q) == 5'h00)
        else $error("nonmaskable edge taken during blanking");
    a_blank_load: assert property (wr_at(bus, OFS_NMICTL) && bus.wdata[8] != edge_sel_q
        |=> blank_cnt_q == 5'h14 ##19 blank_cnt_q == 5'h01 || $past(bus.wr))
        else $error("blanking count wrong");
    a_level_bit: assert property (bus.rd && bus.addr == OFS_NMICTL |=> rd_data_q[15] == $past(nmi_s))
        else $error("level bit does not show pin");
    a_edge_latch_hold: assert property (irq_latch_q[0] && !wr_at(bus, OFS_REQ0) |=> irq_latch_q[0])
        else $error("edge request lost without software clear");
    a_mask_compare: assert property (cpu_req_q.valid |-> cpu_req_q.level > {1'b0, $past(cpu_mask_level)})
        else $error("request not above mask level");
    a_wake_standby: assert property (wakeup_q |-> $past(standby_mode))
        else $error("wake outside standby");
    a_notify_req: assert property (cpu_req_q.valid |-> !irq_notify_n_q)
        else $error("notification missing with request");

    c_nmi_req: cover property (cpu_req_q.nmi ##1 cpu_ack);
    c_irq_edge: cover property ($rose(irq_latch_q[0]) ##[1:20] cpu_req_q.src == 5'h01);
    c_wake: cover property (standby_mode && wakeup_q);
endmodule : pic_top
`default_nettype wire

// ---- hw/pic_pkg.sv ----
`default_nettype none
package pic_pkg;
    // Register offsets, kept as printed
    localparam logic [31:0] OFS_REQ0 = 32'h0400_0004;
    localparam logic [31:0] OFS_REQ1 = 32'h0400_0006;
    localparam logic [31:0] OFS_REQ2 = 32'h0400_0008;
    localparam logic [31:0] OFS_PINSENSE = 32'h0400_0010;
    localparam logic [31:0] OFS_PORTSENSE = 32'h0400_0012;
    localparam logic [31:0] OFS_PORTEN = 32'h0400_0014;
    localparam logic [31:0] OFS_PRIO_C = 32'h0400_0016;
    localparam logic [31:0] OFS_PRIO_D = 32'h0400_0018;
    localparam logic [31:0] OFS_PRIO_E = 32'h0400_001a;
    localparam logic [31:0] OFS_NMICTL = 32'h0fff_fee0;
    localparam logic [31:0] OFS_PRIO_A = 32'hffff_fee2;
    localparam logic [31:0] OFS_PRIO_B = 32'hffff_fee4;
    // Field positions
    localparam int NMICTL_LEVEL_BIT = 15;
    localparam int NMICTL_EDGE_BIT = 8;
    localparam int PINSENSE_DIS_BIT = 15;
    localparam int PINSENSE_OVR_BIT = 14;
    localparam int PRIOD_PLO_POS = 12;
    localparam int PRIOD_PHI_POS = 8;
    // Values after reset
    localparam logic [15:0] REG_RST = 16'h0000;
    localparam logic [7:0] REQ_RST = 8'h00;
    // Levels and counts
    localparam logic [4:0] LVL_NMI = 5'h10;
    localparam logic [4:0] NMI_BLANK_CYC = 5'h14;
    localparam int NUM_IRQ = 6;
    localparam int NUM_PORT = 16;
    localparam int NUM_PERIPH = 12;
    localparam int NUM_SRC = 22;
    // Source codes in default ranking order
    localparam logic [4:0] SRC_NMI = 5'h00;
    localparam logic [4:0] SRC_IRQ0 = 5'h01;
    localparam logic [4:0] SRC_ENC = 5'h07;
    localparam logic [4:0] SRC_PLO = 5'h08;
    localparam logic [4:0] SRC_PHI = 5'h09;
    localparam logic [4:0] SRC_PER0 = 5'h0a;

    // Request presented to the CPU core
    typedef struct packed {
        logic valid;
        logic nmi;
        logic [4:0] level;
        logic [4:0] src;
    } pic_req_s;

    // Register port request
    typedef struct packed {
        logic wr;
        logic rd;
        logic [31:0] addr;
        logic [15:0] wdata;
    } pic_bus_s;
endpackage : pic_pkg
`default_nettype wire

// ---- bench/pic_cpu_model.sv ----
`timescale 1ns/10ps
`default_nettype none
module pic_cpu_model (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire pic_pkg::pic_req_s req,
    input wire logic ack_on,
    output logic cpu_ack
);
    import pic_pkg::*;
    logic busy_q;
    //////////////////////////////////////////////////////////////////////////////
    // One accept pulse per standing request; it then waits for the request to drop
    // so that an acknowledge never lands on a request that has already gone
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            cpu_ack <= 1'b0;
            busy_q <= 1'b0;
        end else begin
            cpu_ack <= ack_on && req.valid && !busy_q && !cpu_ack;
            busy_q <= req.valid && (busy_q || cpu_ack);
        end
    end
endmodule : pic_cpu_model
`default_nettype wire

// ---- bench/tb_pic_top.sv ----
`timescale 1ns/10ps
`default_nettype none
module tb_pic_top;
    import pic_pkg::*;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    pic_bus_s bus = '0;
    logic nmi_pin = 1'b1;
    logic [NUM_IRQ-1:0] pins_n = 6'h3f;
    logic [3:0] enc_n = 4'hf;
    logic [NUM_PORT-1:0] port_in = 16'hffff;
    logic [NUM_PERIPH-1:0] per = 12'h000;
    logic refr = 1'b0, blk = 1'b0, slp = 1'b0, stby = 1'b0, rtc = 1'b0, ack_on = 1'b0;
    logic [3:0] mask = 4'h0;
    logic cpu_ack, wakeup_q, irq_notify_n_q;
    logic [15:0] rd_data_q;
    pic_req_s cpu_req_q;
    int error_cnt = 0;
    int tests_run = 0;
    logic [31:0] ofs [11] = '{OFS_REQ0, OFS_REQ1, OFS_REQ2, OFS_PINSENSE, OFS_PORTSENSE, OFS_PORTEN,
        OFS_PRIO_C, OFS_PRIO_D, OFS_PRIO_E, OFS_PRIO_A, OFS_PRIO_B};

    pic_top u_pic_top (.core_clk(core_clk), .rst_n(rst_n), .bus(bus), .rd_data_q(rd_data_q),
        .nmi_pin(nmi_pin), .ext_req_pins_n(pins_n), .enc_level_pins_n(enc_n), .port_irq_in(port_in),
        .periph_req(per), .refresh_req(refr), .cpu_block_bit(blk), .cpu_mask_level(mask),
        .cpu_ack(cpu_ack), .sleep_mode(slp), .standby_mode(stby), .rtc_osc_used(rtc),
        .cpu_req_q(cpu_req_q), .wakeup_q(wakeup_q), .irq_notify_n_q(irq_notify_n_q));

    pic_cpu_model u_pic_cpu_model (.core_clk(core_clk), .rst_n(rst_n), .req(cpu_req_q),
        .ack_on(ack_on), .cpu_ack(cpu_ack));

    //////////////////////////////////////////////////////////////////////////////
    // Clock and hang guard; the whole run is well under a thousand cycles
    initial begin
        forever #20 core_clk = ~core_clk;
    end

    initial begin
        #100000;
        error_cnt++;
        close_out();
    end

    //////////////////////////////////////////////////////////////////////////////
    // Checking and register port tasks; read data is sampled inside the cycle where it stands
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error at %0t ns: seen %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic rq(input logic v, input logic [4:0] l, input logic [4:0] s);
        if (v) begin
            chk({4'h0, cpu_req_q}, {4'h0, 1'b1, s == SRC_NMI, l, s});
        end else begin
            chk({15'h0000, cpu_req_q.valid}, 16'h0000);
        end
    endtask : rq

    task automatic wr(input logic [31:0] a, input logic [15:0] d);
        bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge core_clk);
        bus <= '0;
        @(posedge core_clk);
    endtask : wr

    task automatic rd(input logic [31:0] a, input logic [15:0] e);
        bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
        @(posedge core_clk);
        bus <= '0;
        #1;
        chk(rd_data_q, e);
        @(posedge core_clk);
    endtask : rd

    // Pin changes need three to five edges to reach the request output
    task automatic settle;
        repeat (6) @(posedge core_clk);
    endtask : settle

    // Low pulse on the nonmaskable pin, then drain through the CPU model if it was taken
    task automatic nmi_pulse(input logic hit);
        nmi_pin <= 1'b0;
        repeat (4) @(posedge core_clk);
        nmi_pin <= 1'b1;
        settle();
        rq(hit, LVL_NMI, SRC_NMI);
        chk({15'h0000, wakeup_q}, {15'h0000, hit & stby});
        ack_on <= 1'b1;
        settle();
        rq(1'b0, 5'h00, 5'h00);
        ack_on <= 1'b0;
    endtask : nmi_pulse

    task automatic close_out;
        $display("Compares %0d, mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : close_out

    //////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        repeat (20) @(posedge core_clk);
        rst_n <= 1'b1;
        @(posedge core_clk);
        rd(OFS_NMICTL, 16'h8000);
        foreach (ofs[i]) begin
            rd(ofs[i], 16'h0000);
            wr(ofs[i], 16'h5a3c);
            rd(ofs[i], (i < 3) ? 16'h0000 : 16'h5a3c);
            wr(ofs[i], 16'h0000);
        end
        rd(32'h0400_0020, 16'h0000);
        $display("End of register test");
        // Edge-sensed pin 0 latches until software clears it
        wr(OFS_PINSENSE, 16'h0001);
        wr(OFS_PRIO_C, 16'h0075);
        pins_n <= 6'h3e;
        repeat (3) @(posedge core_clk);
        pins_n <= 6'h3f;
        settle();
        rq(1'b1, 5'h05, SRC_IRQ0);
        chk({15'h0000, irq_notify_n_q}, 16'h0000);
        rd(OFS_REQ0, 16'h0001);
        wr(OFS_REQ0, 16'h003e);
        settle();
        rq(1'b0, 5'h00, 5'h00);
        // Level-sensed pin 1 follows the pin and the mask
        pins_n <= 6'h3d;
        settle();
        rq(1'b1, 5'h07, SRC_IRQ0 + 5'h01);
        mask <= 4'h7;
        settle();
        rq(1'b0, 5'h00, 5'h00);
        mask <= 4'h6;
        settle();
        rq(1'b1, 5'h07, SRC_IRQ0 + 5'h01);
        pins_n <= 6'h3f;
        settle();
        rq(1'b0, 5'h00, 5'h00);
        // Equal levels and a zero level
        wr(OFS_PINSENSE, 16'h0000);
        wr(OFS_PRIO_C, 16'h0044);
        mask <= 4'h0;
        pins_n <= 6'h3c;
        settle();
        rq(1'b1, 5'h04, SRC_IRQ0);
        wr(OFS_PRIO_C, 16'h0040);
        settle();
        rq(1'b1, 5'h04, SRC_IRQ0 + 5'h01);
        pins_n <= 6'h3f;
        $display("End of pin test");
        // Every encoded pattern
        for (int p = 0; p < 16; p++) begin
            enc_n <= 4'(p);
            settle();
            rq(p < 15, 5'(15 - p), SRC_ENC);
        end
        // Peripheral source, port input, standby wake-up and refresh notification
        wr(OFS_PRIO_A, 16'h0009);
        per <= 12'h001;
        settle();
        rq(1'b1, 5'h09, SRC_PER0);
        per <= 12'h000;
        wr(OFS_PORTEN, 16'h0001);
        wr(OFS_PRIO_D, 16'h6000);
        port_in <= 16'hfffe;
        settle();
        rq(1'b1, 5'h06, SRC_PLO);
        rd(OFS_REQ1, 16'h0001);
        stby <= 1'b1;
        rtc <= 1'b1;
        settle();
        chk({15'h0000, wakeup_q}, 16'h0001);
        rtc <= 1'b0;
        settle();
        chk({15'h0000, wakeup_q}, 16'h0000);
        port_in <= 16'hffff;
        stby <= 1'b0;
        refr <= 1'b1;
        settle();
        chk({15'h0000, irq_notify_n_q}, 16'h0000);
        refr <= 1'b0;
        settle();
        chk({15'h0000, irq_notify_n_q}, 16'h0001);
        $display("End of source test");
        // Nonmaskable input: above any mask, edge choice, blanking, block and wake rules
        mask <= 4'hf;
        nmi_pin <= 1'b0;
        settle();
        rd(OFS_NMICTL, 16'h0000);
        nmi_pin <= 1'b1;
        settle();
        rq(1'b1, LVL_NMI, SRC_NMI);
        ack_on <= 1'b1;
        settle();
        ack_on <= 1'b0;
        wr(OFS_NMICTL, 16'h0100);
        nmi_pulse(1'b0);
        repeat (25) @(posedge core_clk);
        nmi_pulse(1'b1);
        rd(OFS_NMICTL, 16'h8100);
        blk <= 1'b1;
        wr(OFS_PINSENSE, 16'h4000);
        nmi_pulse(1'b1);
        wr(OFS_PINSENSE, 16'h0000);
        stby <= 1'b1;
        nmi_pulse(1'b1);
        slp <= 1'b1;
        stby <= 1'b0;
        nmi_pulse(1'b1);
        slp <= 1'b0;
        nmi_pulse(1'b0);
        wr(OFS_PINSENSE, 16'h8000);
        stby <= 1'b1;
        nmi_pulse(1'b0);
        $display("End of nonmaskable test");
        close_out();
    end
endmodule : tb_pic_top
`default_nettype wire
